// file: design/tblc_pkg.sv
// Package: offsets, field layouts, reset values and types of the config bank
package tblc_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] TBLC_OFS_TEST    = 12'h008;
    localparam logic [11:0] TBLC_OFS_REFBIAS = 12'h00C;
    localparam logic [11:0] TBLC_OFS_LEAD_OFF_CONTROL    = 12'h010;
    localparam logic [11:0] TBLC_OFS_IRQ_ST  = 12'h020;
    localparam logic [11:0] TBLC_OFS_IRQ_EN  = 12'h024;
    localparam logic [11:0] TBLC_OFS_IRQ_CLR = 12'h028;
    localparam logic [11:0] TBLC_OFS_MUX     = 12'h02C;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] TBLC_RST_TEST    = 8'hC0;
    localparam logic [7:0] TBLC_RST_REFBIAS = 8'h60;
    localparam logic [7:0] TBLC_RST_LEAD_OFF_CONTROL    = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TBLC_TEST_SRC_BIT   = 4;
    localparam int TBLC_TEST_AMP_BIT   = 2;
    localparam int TBLC_RB_REFBUF_BIT  = 7;
    localparam int TBLC_RB_MEAS_BIT    = 4;
    localparam int TBLC_RB_BREF_BIT    = 3;
    localparam int TBLC_RB_BBUF_BIT    = 2;
    localparam int TBLC_RB_SENSE_BIT   = 1;
    localparam int TBLC_RB_STAT_BIT    = 0;

    localparam logic [2:0] TBLC_MUX_BIAS = 3'h2;
    localparam int TBLC_NUM_IRQ        = 2;
    localparam int TBLC_IRQ_OFF_BIT    = 0;
    localparam int TBLC_IRQ_ON_BIT     = 1;

    // ------------------------------------------------------------------
    // Timing: divider exponents of the system clock
    // ------------------------------------------------------------------
    localparam int TBLC_TEST_DIV_SLOW = 21;
    localparam int TBLC_TEST_DIV_FAST = 20;
    localparam int TBLC_LEAD_OFF_CONTROL_DIV_SLOW = 18;
    localparam int TBLC_LEAD_OFF_CONTROL_DIV_FAST = 16;
    localparam int TBLC_CNT_W         = 22;

    typedef enum logic [1:0] {
        TBLC_TF_SLOW,
        TBLC_TF_FAST,
        TBLC_TF_UNUSED,
        TBLC_TF_DC
    } tblc_tfreq_t;

    typedef enum logic [1:0] {
        TBLC_LF_DC,
        TBLC_LF_SLOW,
        TBLC_LF_FAST,
        TBLC_LF_DRATE
    } tblc_lfreq_t;

    typedef struct packed {
        logic        fixed_hi;
        logic        test_internal;
        logic        test_amplitude_select;
        tblc_tfreq_t test_frequency_select;
    } tblc_test_t;

    typedef struct packed {
        logic reference_buffer_enable;
        logic bias_measure_route;
        logic bias_reference_internal;
        logic bias_buffer_enable;
        logic bias_sense_enable;
    } tblc_refbias_t;

    typedef struct packed {
        logic [2:0]  comparator_threshold;
        logic [1:0]  excitation_current_select;
        tblc_lfreq_t detection_frequency_select;
    } tblc_lead_off_control_t;

endpackage : tblc_pkg

// file: design/tblc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module tblc_sync
    import tblc_pkg::*;
(
    input  wire logic REF_CLK,
    input  wire logic RST_N,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_q;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            sh_q <= 3'h0;
        end else begin
            sh_q <= {sh_q[1:0], din};
        end
    end

    // Stage 0 feeds only stage 1; change accepted when stages 1 and 2 agree
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            dout <= 1'b0;
        end else if (sh_q[1] == sh_q[2]) begin
            dout <= sh_q[2];
        end
    end
endmodule : tblc_sync

// file: design/tblc_divider.sv
// Free-running divider producing one-cycle ticks at clock / 2^n
`timescale 1ns/1ps
module tblc_divider
    import tblc_pkg::*;
#(
    parameter int CNT_W = TBLC_CNT_W
)(
    input  wire logic             REF_CLK,
    input  wire logic             RST_N,
    input  wire logic [4:0]       exp_sel,
    output logic                  tick,
    output logic                  phase
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] mask;

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_comb begin
        mask = CNT_W'((1 << exp_sel) - 1);
        tick = ((cnt_q & mask) == mask);
        phase = (exp_sel == 5'h0) ? 1'b0 : cnt_q[exp_sel - 5'h1];
    end
endmodule : tblc_divider

// file: design/tblc_regs.sv
// Test-signal, reference/bias and lead-off configuration bank on APB
//
// Overview of operation
// R1 - Host writes 110 on top, 0 bit3
// R2 - Bit 4 picks internal test source
// R3 - Bit 2 doubles calibration amplitude
// R4 - Frequency field: /2^21, /2^20, unused, dc
// R5 - Host writes ones to bits 6,5
// R6 - Bit 7 enables reference buffer
// R7 - Bit 4 routes bias input to mux 010
// R8 - Bit 3 picks internal bias reference
// R9 - Bit 2 powers bias buffer
// R10 - Bit 1 enables bias sense
// R11 - Bit 0 reads live bias lead-off status
// R12 - Threshold code drives paired comparator levels
// R13 - Host keeps lead-off bit 4 zero
// R14 - Current field selects excitation magnitude
// R15 - Frequency field selects dc or ac detection
// R16 - Mux code 010 with route measures bias
// R17 - Readback returns written bits, status live
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module tblc_regs
    import tblc_pkg::*;
#(
    parameter int NUM_CH = 8
)(
    input  wire logic                REF_CLK,
    input  wire logic                RST_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [11:0]         PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                BIAS_LEAD_OFF_CONTROL_IN,
    input  wire logic                DRATE_TICK,
    output tblc_test_t               TEST_CFG,
    output tblc_refbias_t            REFBIAS_CFG,
    output tblc_lead_off_control_t               LEAD_OFF_CONTROL_CFG,
    output logic                     TEST_PULSE,
    output logic                     LEAD_OFF_CONTROL_EXCITE,
    output logic      [NUM_CH-1:0]   BIAS_ROUTE_CH,
    output logic                     IRQ
);
    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [7:0]              test_q;
    logic [7:0]              refbias_q;
    logic [7:0]              lead_off_control_q;
    logic [3*NUM_CH-1:0]     mux_q;
    logic [TBLC_NUM_IRQ-1:0] irq_st_q;
    logic [TBLC_NUM_IRQ-1:0] irq_en_q;
    logic [TBLC_NUM_IRQ-1:0] irq_set;
    logic [TBLC_NUM_IRQ-1:0] irq_clr;
    logic                    bias_off;
    logic                    bias_off_q;
    logic                    wr_en;
    logic                    rd_hit;
    logic                    drate_q;
    logic [1:0]              drate_cnt_q;
    logic                    test_tick;
    logic                    test_phase;
    logic                    lead_off_control_tick;
    logic                    lead_off_control_phase;
    logic [4:0]              test_exp;
    logic [4:0]              lead_off_control_exp;

    // ------------------------------------------------------------------
    // APB decode: zero wait states, unmapped address gives an error
    // ------------------------------------------------------------------
    assign PREADY = 1'b1;
    assign wr_en  = PSEL && PENABLE && PWRITE;

    always_comb begin
        case (PADDR)
            TBLC_OFS_TEST, TBLC_OFS_REFBIAS, TBLC_OFS_LEAD_OFF_CONTROL,
            TBLC_OFS_IRQ_ST, TBLC_OFS_IRQ_EN, TBLC_OFS_IRQ_CLR,
            TBLC_OFS_MUX: rd_hit = 1'b1;
            default:      rd_hit = 1'b0;
        endcase
    end

    assign PSLVERR = PSEL && PENABLE && !rd_hit;

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            test_q <= TBLC_RST_TEST;
        end else if (wr_en && PADDR == TBLC_OFS_TEST) begin
            test_q <= PWDATA[7:0]; // R17
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            refbias_q <= TBLC_RST_REFBIAS;
        end else if (wr_en && PADDR == TBLC_OFS_REFBIAS) begin
            // Status bit is never stored; it reads the live detector
            refbias_q <= {PWDATA[7:1], 1'b0}; // R17
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            lead_off_control_q <= TBLC_RST_LEAD_OFF_CONTROL;
        end else if (wr_en && PADDR == TBLC_OFS_LEAD_OFF_CONTROL) begin
            lead_off_control_q <= PWDATA[7:0]; // R17
        end
    end

    // Per-channel input selection codes, kept here for the bias route
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mux_q <= '0;
        end else if (wr_en && PADDR == TBLC_OFS_MUX) begin
            mux_q <= PWDATA[3*NUM_CH-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------------
    always_comb begin
        TEST_CFG.fixed_hi              = test_q[7];
        TEST_CFG.test_internal         = test_q[TBLC_TEST_SRC_BIT];   // R2
        TEST_CFG.test_amplitude_select = test_q[TBLC_TEST_AMP_BIT];   // R3
        TEST_CFG.test_frequency_select = tblc_tfreq_t'(test_q[1:0]);
        REFBIAS_CFG.reference_buffer_enable =
            refbias_q[TBLC_RB_REFBUF_BIT];                            // R6
        REFBIAS_CFG.bias_measure_route = refbias_q[TBLC_RB_MEAS_BIT];
        REFBIAS_CFG.bias_reference_internal =
            refbias_q[TBLC_RB_BREF_BIT];                              // R8
        REFBIAS_CFG.bias_buffer_enable = refbias_q[TBLC_RB_BBUF_BIT]; // R9
        REFBIAS_CFG.bias_sense_enable  = refbias_q[TBLC_RB_SENSE_BIT];// R10
        LEAD_OFF_CONTROL_CFG.comparator_threshold      = lead_off_control_q[7:5];             // R12
        LEAD_OFF_CONTROL_CFG.excitation_current_select = lead_off_control_q[3:2];             // R14
        LEAD_OFF_CONTROL_CFG.detection_frequency_select =
            tblc_lfreq_t'(lead_off_control_q[1:0]);                               // R15
    end

    // Channel whose mux code is 010 sees the bias input when routed
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_route
            assign BIAS_ROUTE_CH[g] = refbias_q[TBLC_RB_MEAS_BIT] &&
                (mux_q[3*g +: 3] == TBLC_MUX_BIAS); // R7 R16
        end
    endgenerate

    // ------------------------------------------------------------------
    // Test-signal and lead-off timing
    // ------------------------------------------------------------------
    always_comb begin
        case (tblc_tfreq_t'(test_q[1:0]))
            TBLC_TF_SLOW: test_exp = 5'(TBLC_TEST_DIV_SLOW); // R4
            TBLC_TF_FAST: test_exp = 5'(TBLC_TEST_DIV_FAST); // R4
            default:      test_exp = 5'(TBLC_TEST_DIV_SLOW);
        endcase
        case (tblc_lfreq_t'(lead_off_control_q[1:0]))
            TBLC_LF_SLOW: lead_off_control_exp = 5'(TBLC_LEAD_OFF_CONTROL_DIV_SLOW); // R15
            TBLC_LF_FAST: lead_off_control_exp = 5'(TBLC_LEAD_OFF_CONTROL_DIV_FAST); // R15
            default:      lead_off_control_exp = 5'(TBLC_LEAD_OFF_CONTROL_DIV_SLOW);
        endcase
    end

    tblc_divider #(.CNT_W(TBLC_CNT_W)) u_test_div (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .exp_sel (test_exp),
        .tick    (test_tick),
        .phase   (test_phase)
    );

    tblc_divider #(.CNT_W(TBLC_CNT_W)) u_lead_off_control_div (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .exp_sel (lead_off_control_exp),
        .tick    (lead_off_control_tick),
        .phase   (lead_off_control_phase)
    );

    // Data-rate ticks from another domain: edge of synchronised level
    logic drate_s;
    tblc_sync u_drate_sync (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .din     (DRATE_TICK),
        .dout    (drate_s)
    );

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            drate_q     <= 1'b0;
            drate_cnt_q <= 2'h0;
        end else begin
            drate_q <= drate_s;
            if (drate_s && !drate_q) begin
                drate_cnt_q <= drate_cnt_q + 2'h1; // R15
            end
        end
    end

    // Test pulse: square wave, steady high in dc mode, low for external source or unused code
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TEST_PULSE <= 1'b0;
        end else if (!test_q[TBLC_TEST_SRC_BIT]) begin
            TEST_PULSE <= 1'b0;
        end else begin
            case (tblc_tfreq_t'(test_q[1:0]))
                TBLC_TF_DC:     TEST_PULSE <= 1'b1;       // R4
                TBLC_TF_UNUSED: TEST_PULSE <= 1'b0;
                default:        TEST_PULSE <= test_phase; // R4
            endcase
        end
    end

    // Excitation: steady in dc mode, alternating otherwise
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            LEAD_OFF_CONTROL_EXCITE <= 1'b0;
        end else begin
            case (tblc_lfreq_t'(lead_off_control_q[1:0]))
                TBLC_LF_DC:    LEAD_OFF_CONTROL_EXCITE <= 1'b1;
                TBLC_LF_DRATE: LEAD_OFF_CONTROL_EXCITE <= drate_cnt_q[1]; // R15
                default:       LEAD_OFF_CONTROL_EXCITE <= lead_off_control_phase;     // R15
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Bias lead-off status and interrupts
    // ------------------------------------------------------------------
    tblc_sync u_bias_sync (
        .REF_CLK (REF_CLK),
        .RST_N   (RST_N),
        .din     (BIAS_LEAD_OFF_CONTROL_IN),
        .dout    (bias_off)
    );

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            bias_off_q <= 1'b0;
        end else begin
            bias_off_q <= bias_off;
        end
    end

    assign irq_set[TBLC_IRQ_OFF_BIT] = bias_off && !bias_off_q;
    assign irq_set[TBLC_IRQ_ON_BIT]  = !bias_off && bias_off_q;
    assign irq_clr = (wr_en && PADDR == TBLC_OFS_IRQ_CLR) ?
                     PWDATA[TBLC_NUM_IRQ-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_st_q <= '0;
        end else begin
            irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_en_q <= '0;
        end else if (wr_en && PADDR == TBLC_OFS_IRQ_EN) begin
            irq_en_q <= PWDATA[TBLC_NUM_IRQ-1:0];
        end
    end

    assign IRQ = |(irq_st_q & irq_en_q);

    // ------------------------------------------------------------------
    // Read data, registered in the setup cycle
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL && !PENABLE && !PWRITE) begin
            case (PADDR)
                TBLC_OFS_TEST:    PRDATA <= {24'h0, test_q};
                TBLC_OFS_REFBIAS: PRDATA <= {24'h0, refbias_q[7:1],
                                             bias_off};        // R11 R17
                TBLC_OFS_LEAD_OFF_CONTROL:    PRDATA <= {24'h0, lead_off_control_q};
                TBLC_OFS_IRQ_ST:  PRDATA <= {30'h0, irq_st_q};
                TBLC_OFS_IRQ_EN:  PRDATA <= {30'h0, irq_en_q};
                TBLC_OFS_MUX:     PRDATA <= {8'h0, mux_q};
                default:          PRDATA <= 32'h0000_0000;
            endcase
        end
    end
endmodule : tblc_regs

// file: bench/tblc_regs_assertions.sv
// Checker for the port behaviour of the configuration bank
`timescale 1ns/1ps
module tblc_regs_assertions
    import tblc_pkg::*;
#(
    parameter int NUM_CH = 8
)(
    input wire logic                REF_CLK,
    input wire logic                RST_N,
    input wire logic                PSEL,
    input wire logic                PENABLE,
    input wire logic                PWRITE,
    input wire logic [11:0]         PADDR,
    input wire logic [31:0]         PWDATA,
    input wire logic                PREADY,
    input wire logic                PSLVERR,
    input wire tblc_test_t          TEST_CFG,
    input wire tblc_refbias_t       REFBIAS_CFG,
    input wire tblc_lead_off_control_t          LEAD_OFF_CONTROL_CFG,
    input wire logic                TEST_PULSE,
    input wire logic                LEAD_OFF_CONTROL_EXCITE,
    input wire logic [NUM_CH-1:0]   BIAS_ROUTE_CH
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    logic wr_acc;
    logic mapped;
    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign mapped = PADDR inside {TBLC_OFS_TEST, TBLC_OFS_REFBIAS,
        TBLC_OFS_LEAD_OFF_CONTROL, TBLC_OFS_IRQ_ST, TBLC_OFS_IRQ_EN, TBLC_OFS_IRQ_CLR,
        TBLC_OFS_MUX};

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    property p_reset_vals;
        disable iff (1'b0) !RST_N |=> TEST_CFG == 5'h10
            && REFBIAS_CFG == 5'h00 && LEAD_OFF_CONTROL_CFG == 7'h00;
    endproperty
    a_reset_vals: assert property (p_reset_vals)
        else $error("config outputs wrong after reset");
    property p_wr_test;
        wr_acc && PADDR == TBLC_OFS_TEST |=> TEST_CFG ==
            {$past(PWDATA[7]), $past(PWDATA[4]), $past(PWDATA[2:0])};
    endproperty
    a_wr_test: assert property (p_wr_test)
        else $error("test config does not follow write");
    property p_wr_refbias;
        wr_acc && PADDR == TBLC_OFS_REFBIAS |=> REFBIAS_CFG ==
            {$past(PWDATA[7]), $past(PWDATA[4:1])};
    endproperty
    a_wr_refbias: assert property (p_wr_refbias)
        else $error("reference and bias config does not follow write");
    property p_wr_lead_off_control;
        wr_acc && PADDR == TBLC_OFS_LEAD_OFF_CONTROL |=> LEAD_OFF_CONTROL_CFG ==
            {$past(PWDATA[7:5]), $past(PWDATA[3:0])};
    endproperty
    a_wr_lead_off_control: assert property (p_wr_lead_off_control)
        else $error("lead-off config does not follow write");
    property p_ext_src;
        (!TEST_CFG.test_internal)[*3] |-> !TEST_PULSE;
    endproperty
    a_ext_src: assert property (p_ext_src)
        else $error("test signal active with external source");
    property p_dc_level;
        (TEST_CFG.test_internal
            && TEST_CFG.test_frequency_select == TBLC_TF_DC)[*3]
            |-> TEST_PULSE;
    endproperty
    a_dc_level: assert property (p_dc_level)
        else $error("test signal not at dc level");
    property p_unused;
        (TEST_CFG.test_frequency_select == TBLC_TF_UNUSED)[*3]
            |-> !TEST_PULSE;
    endproperty
    a_unused: assert property (p_unused)
        else $error("test signal active on unused code");
    property p_excite_dc;
        (LEAD_OFF_CONTROL_CFG.detection_frequency_select == TBLC_LF_DC)[*4]
            |-> LEAD_OFF_CONTROL_EXCITE;
    endproperty
    a_excite_dc: assert property (p_excite_dc)
        else $error("excitation not steady in dc detection");
    property p_route;
        |BIAS_ROUTE_CH |-> REFBIAS_CFG.bias_measure_route;
    endproperty
    a_route: assert property (p_route)
        else $error("bias routed while route bit clear");
    property p_err;
        PSEL && PENABLE |-> PREADY && (PSLVERR == !mapped);
    endproperty
    a_err: assert property (p_err)
        else $error("bus response wrong for address");
endmodule : tblc_regs_assertions

bind tblc_regs tblc_regs_assertions #(.NUM_CH(NUM_CH)) u_chk (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TEST_CFG(TEST_CFG), .REFBIAS_CFG(REFBIAS_CFG),
    .LEAD_OFF_CONTROL_CFG(LEAD_OFF_CONTROL_CFG), .TEST_PULSE(TEST_PULSE),
    .LEAD_OFF_CONTROL_EXCITE(LEAD_OFF_CONTROL_EXCITE), .BIAS_ROUTE_CH(BIAS_ROUTE_CH));

// file: bench/tblc_host_model.sv
// Host controller model issuing register transfers on the bus
`timescale 1ns/1ps
module tblc_host_model
    import tblc_pkg::*;
(
    input  wire logic        REF_CLK,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Fixed bits are forced here so every write is a legal one
    // ------------------------------------------------------------
    function automatic logic [31:0] fix(input logic [11:0] a,
                                        input logic [31:0] d);
        case (a)
            TBLC_OFS_TEST:    fix = (d & 32'h0000_0017) | 32'h0000_00C0;
            TBLC_OFS_REFBIAS: fix = d | 32'h0000_0060;
            TBLC_OFS_LEAD_OFF_CONTROL:    fix = d & 32'hFFFF_FFEF;
            default:          fix = d;
        endcase
    endfunction : fix

    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic err);
        @(posedge REF_CLK);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? fix(a, wd) : 32'h0000_0000;
        @(posedge REF_CLK);
        penable <= 1'b1;
        do @(posedge REF_CLK); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic write(input logic [11:0] a, input logic [31:0] d,
                         output logic err);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, dummy, err);
    endtask : write

    task automatic read(input logic [11:0] a, output logic [31:0] d,
                        output logic err);
        xfer(a, 1'b0, 32'h0000_0000, d, err);
    endtask : read
endmodule : tblc_host_model

// file: bench/test_tblc_regs.sv
// Self-checking bench for the configuration bank
`timescale 1ns/1ps
module test_tblc_regs
    import tblc_pkg::*;
;
    logic REF_CLK = 1'b0, RST_N = 1'b0, BIAS_LEAD_OFF_CONTROL_IN = 1'b0;
    logic DRATE_TICK = 1'b0;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    tblc_test_t TEST_CFG;
    tblc_refbias_t REFBIAS_CFG;
    tblc_lead_off_control_t LEAD_OFF_CONTROL_CFG;
    logic TEST_PULSE, LEAD_OFF_CONTROL_EXCITE, IRQ, er, prev;
    logic [7:0] BIAS_ROUTE_CH;
    int num_errors = 0, tests_run = 0, tog = 0;
    logic [11:0] ofs [3] = '{TBLC_OFS_TEST, TBLC_OFS_REFBIAS, TBLC_OFS_LEAD_OFF_CONTROL};
    logic [31:0] pat [3] = '{32'h17, 32'h9F, 32'hFF};
    logic [31:0] exp1 [3] = '{32'hD7, 32'hFE, 32'hEF};
    logic [31:0] exp0 [3] = '{32'hC0, 32'h60, 32'h00};

    always #25 REF_CLK = ~REF_CLK;

    tblc_host_model u_host (.REF_CLK(REF_CLK), .psel(PSEL),
        .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR), .pwdata(PWDATA),
        .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));

    tblc_regs #(.NUM_CH(8)) u_dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .BIAS_LEAD_OFF_CONTROL_IN(BIAS_LEAD_OFF_CONTROL_IN),
        .DRATE_TICK(DRATE_TICK), .TEST_CFG(TEST_CFG),
        .REFBIAS_CFG(REFBIAS_CFG), .LEAD_OFF_CONTROL_CFG(LEAD_OFF_CONTROL_CFG),
        .TEST_PULSE(TEST_PULSE), .LEAD_OFF_CONTROL_EXCITE(LEAD_OFF_CONTROL_EXCITE),
        .BIAS_ROUTE_CH(BIAS_ROUTE_CH), .IRQ(IRQ));

    // Counts excitation edges for the data-rate mode
    always @(posedge REF_CLK) begin
        if (LEAD_OFF_CONTROL_EXCITE !== prev) tog++;
        prev = LEAD_OFF_CONTROL_EXCITE;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        u_host.read(a, rd, er);
        chk(rd, exp, "register read");
    endtask : rd_chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.write(a, d, er);
    endtask : wr

    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask : cyc

    // Pulses are stretched so the input synchroniser sees each one
    task automatic pulses(input int n);
        repeat (n) begin
            DRATE_TICK <= 1'b1;
            cyc(4);
            DRATE_TICK <= 1'b0;
            cyc(4);
        end
    endtask : pulses

    task automatic finish_test;
        $display("Checks run: %0d, errors: %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test

    initial begin
        cyc(6000);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        cyc(6);
        RST_N <= 1'b1;
        for (int k = 0; k < 3; k++) rd_chk(ofs[k], exp0[k]);
        for (int k = 0; k < 3; k++) begin
            wr(ofs[k], pat[k]);
            rd_chk(ofs[k], exp1[k]);
            wr(ofs[k], 32'h0);
            rd_chk(ofs[k], exp0[k]);
        end
        wr(TBLC_OFS_TEST, 32'h13);
        cyc(4);
        chk(TEST_PULSE, 1'b1, "dc test level");
        wr(TBLC_OFS_TEST, 32'h12);
        cyc(4);
        chk(TEST_PULSE, 1'b0, "unused test code");
        wr(TBLC_OFS_TEST, 32'h03);
        cyc(4);
        chk(TEST_PULSE, 1'b0, "external test source");
        wr(TBLC_OFS_LEAD_OFF_CONTROL, 32'h0);
        cyc(4);
        chk(LEAD_OFF_CONTROL_EXCITE, 1'b1, "dc detection");
        wr(TBLC_OFS_LEAD_OFF_CONTROL, 32'h3);
        pulses(2);
        tog = 0;
        pulses(8);
        chk(tog, 4, "data-rate excitation toggles");
        wr(TBLC_OFS_MUX, 32'h80);
        wr(TBLC_OFS_REFBIAS, 32'h0);
        cyc(2);
        chk(BIAS_ROUTE_CH, 8'h00, "route open");
        wr(TBLC_OFS_REFBIAS, 32'h10);
        cyc(2);
        chk(BIAS_ROUTE_CH, 8'h04, "route channel 2");
        wr(TBLC_OFS_IRQ_EN, 32'h3);
        BIAS_LEAD_OFF_CONTROL_IN <= 1'b1;
        cyc(8);
        rd_chk(TBLC_OFS_REFBIAS, 32'h71);
        rd_chk(TBLC_OFS_IRQ_ST, 32'h1);
        chk(IRQ, 1'b1, "disconnect interrupt");
        wr(TBLC_OFS_IRQ_CLR, 32'h1);
        cyc(1);
        chk(IRQ, 1'b0, "interrupt cleared");
        BIAS_LEAD_OFF_CONTROL_IN <= 1'b0;
        cyc(8);
        rd_chk(TBLC_OFS_REFBIAS, 32'h70);
        rd_chk(TBLC_OFS_IRQ_ST, 32'h2);
        chk(IRQ, 1'b1, "reconnect interrupt");
        wr(TBLC_OFS_IRQ_EN, 32'h0);
        cyc(1);
        chk(IRQ, 1'b0, "interrupt masked");
        u_host.read(12'h0FC, rd, er);
        chk(rd, 32'h0, "unmapped read data");
        chk(er, 1'b1, "unmapped error");
        finish_test();
    end
endmodule : test_tblc_regs
